//--- core/cosp_packer.sv
`timescale 1ns/10ps
module cosp_packer #(
    parameter int NUM_SLOTS = cosp_pkg::NUM_SLOTS,
    parameter int NUM_SRC   = cosp_pkg::NUM_SOURCES,
    parameter logic [27:0] MS_CYCLES = cosp_pkg::MS_CYCLES
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire logic [NUM_SRC*32-1:0]         src_value,
    input  wire logic [NUM_SRC-1:0]            src_valid,
    input  wire logic                          cfg_wr,
    input  wire logic                          cfg_wr_msg,
    input  wire logic [3:0]                    cfg_wr_slot,
    input  wire cosp_pkg::cosp_slot_type       cfg_wr_slot_data,
    input  wire cosp_pkg::cosp_msg_type        cfg_wr_msg_data,
    input  wire logic                          cfg_wr_identity,
    input  wire logic                          cfg_wr_bitrate,
    input  wire logic [15:0]                   cfg_bitrate,
    input  wire logic                          tx_request,
    input  wire logic                          tx_ready,
    output logic                               cfg_ack,
    output logic                               cfg_reject,
    output logic                               nv_save,
    output cosp_pkg::cosp_msg_type             nv_msg,
    output logic                               nv_bitrate_save,
    output logic [15:0]                        nv_bitrate,
    output logic                               blocks_reset,
    output logic                               addr_reclaim,
    output logic                               tx_valid,
    output cosp_pkg::cosp_frame_type           tx_frame
);
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_BUILD = 2'h1,
        ST_SEND  = 2'h3
    } cosp_state_type;

    cosp_pkg::cosp_slot_type slot_q [NUM_SLOTS];
    cosp_pkg::cosp_msg_type  msg_q;
    cosp_state_type          state_q;
    cosp_state_type          state_d;
    logic [63:0]             field_w [NUM_SLOTS];
    logic [63:0]             mask_w  [NUM_SLOTS];
    logic [63:0]             data_w;
    logic [63:0]             data_q;
    logic [27:0]             cyc_q;
    logic [13:0]             ms_q;
    logic                    tick_ms;
    logic                    period_hit;
    logic                    req_pend_q;
    logic                    start_w;
    logic                    pgn_bad;
    logic                    wr_ok;
    logic                    cfg_ack_q;
    logic                    cfg_reject_q;
    logic                    nv_save_q;
    logic                    nv_br_q;
    logic [15:0]             nv_bitrate_q;
    logic                    blocks_reset_q;
    logic                    reclaim_q;
    cosp_pkg::cosp_frame_type frame_q;

    function automatic cosp_pkg::cosp_slot_type slot_default(input int idx);
        cosp_pkg::cosp_slot_type s;
        s.kind     = cosp_pkg::SIG_UNDEF;
        s.src      = cosp_pkg::SRC_NONE;
        s.byte_pos = cosp_pkg::POS_ONE;
        s.bit_pos  = cosp_pkg::POS_ONE;
        s.size     = cosp_pkg::SIZE_ONE;
        s.gain     = cosp_pkg::GAIN_UNIT;
        s.offset   = cosp_pkg::OFS_ZERO;
        if (idx < 2) begin
            s.kind   = cosp_pkg::SIG_CONT;
            s.size   = cosp_pkg::SIZE_SIXTEEN;
            s.gain   = cosp_pkg::GAIN_CONT_DEF;
            s.offset = cosp_pkg::OFS_CONT_DEF;
            s.src    = (idx == 0) ? cosp_pkg::SRC_PITCH : cosp_pkg::SRC_ROLL;
        end
        if (idx == 1) begin
            s.byte_pos = cosp_pkg::POS_THREE;
        end
        return s;
    endfunction

    // A bad group number rejects the whole message write
    assign pgn_bad = cfg_wr_msg && (cfg_wr_msg_data.pgn == cosp_pkg::PGN_RESERVED);
    assign wr_ok   = cfg_wr && !pgn_bad && (cfg_wr_msg || cfg_wr_slot < 4'(NUM_SLOTS));

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
            logic [31:0] val_w;
            logic        vld_w;
            assign val_w = src_value[slot_q[gi].src*32 +: 32];
            // Source zero stands for not connected and reads as undefined
            assign vld_w = (slot_q[gi].src != cosp_pkg::SRC_NONE) && src_valid[slot_q[gi].src];
            cosp_slot_coder u_coder (
                .cfg   (slot_q[gi]),
                .value (val_w),
                .valid (vld_w),
                .field (field_w[gi]),
                .mask  (mask_w[gi])
            );
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    slot_q[gi] <= slot_default(gi);
                end else if (wr_ok && !cfg_wr_msg && cfg_wr_slot == 4'(gi)) begin
                    slot_q[gi] <= cfg_wr_slot_data;
                end
            end
        end
    endgenerate

    always_comb begin
        data_w = 64'hffff_ffff_ffff_ffff;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            data_w = (data_w & ~mask_w[i]) | field_w[i];
        end
    end

    assign tick_ms    = (cyc_q == MS_CYCLES - 28'h1);
    assign period_hit = tick_ms && (msg_q.rate_ms != cosp_pkg::RATE_ON_REQ)
                        && (ms_q + 14'h1 >= msg_q.rate_ms);
    assign start_w    = msg_q.tx_en && (period_hit || req_pend_q || tx_request);

    always_comb begin
        case (state_q)
            ST_IDLE:  state_d = (start_w && !blocks_reset_q) ? ST_BUILD : ST_IDLE;
            ST_BUILD: state_d = ST_SEND;
            ST_SEND:  state_d = tx_ready ? ST_IDLE : ST_SEND;
            default:  state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            msg_q <= '{cosp_pkg::PGN_DEFAULT, 1'b0, cosp_pkg::RATE_DEFAULT,
                       cosp_pkg::DEST_DEFAULT, cosp_pkg::LEN_DEFAULT, cosp_pkg::PRIO_DEFAULT};
        end else if (wr_ok && cfg_wr_msg) begin
            msg_q <= cfg_wr_msg_data;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cyc_q <= 28'h0;
            ms_q  <= 14'h0;
        end else if (blocks_reset_q || tick_ms) begin
            cyc_q <= 28'h0;
            ms_q  <= (blocks_reset_q || period_hit) ? 14'h0 : ms_q + 14'h1;
        end else begin
            cyc_q <= cyc_q + 28'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            req_pend_q <= 1'b0;
        end else if (tx_request && state_q != ST_IDLE) begin
            req_pend_q <= 1'b1;
        end else if (state_q == ST_IDLE && start_w && !blocks_reset_q) begin
            req_pend_q <= 1'b0;
        end else if (blocks_reset_q) begin
            req_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            data_q  <= 64'hffff_ffff_ffff_ffff;
            frame_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_IDLE) begin
                data_q <= data_w;
            end
            if (state_q == ST_BUILD) begin
                frame_q <= '{msg_q.pgn, msg_q.dest, msg_q.len, msg_q.prio, data_q};
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_ack_q      <= 1'b0;
            cfg_reject_q   <= 1'b0;
            nv_save_q      <= 1'b0;
            nv_br_q        <= 1'b0;
            nv_bitrate_q   <= 16'h0;
            blocks_reset_q <= 1'b0;
            reclaim_q      <= 1'b0;
        end else begin
            cfg_ack_q      <= wr_ok;
            cfg_reject_q   <= cfg_wr && !wr_ok;
            nv_save_q      <= wr_ok;
            blocks_reset_q <= wr_ok || (cfg_wr_bitrate && !cfg_wr);
            reclaim_q      <= wr_ok && cfg_wr_identity;
            nv_br_q        <= cfg_wr_bitrate;
            if (cfg_wr_bitrate) begin
                nv_bitrate_q <= cfg_bitrate;
            end
        end
    end

    assign cfg_ack         = cfg_ack_q;
    assign cfg_reject      = cfg_reject_q;
    assign nv_save         = nv_save_q;
    assign nv_msg          = msg_q;
    assign nv_bitrate_save = nv_br_q;
    assign nv_bitrate      = nv_bitrate_q;
    assign blocks_reset    = blocks_reset_q;
    assign addr_reclaim    = reclaim_q;
    assign tx_valid        = (state_q == ST_SEND);
    assign tx_frame        = frame_q;
endmodule // cosp_packer

//--- core/cosp_pkg.sv
package cosp_pkg;
    localparam int NUM_SLOTS      = 10;
    localparam int DATA_BITS      = 64;
    localparam int BYTE_BITS      = 8;
    localparam int SRC_BITS       = 32;
    localparam int SIZE_MAX       = 32;
    localparam int NUM_SOURCES    = 16;
    localparam int SEL_BITS       = 4;
    localparam int FRAC_BITS      = 16;
    localparam int OFS_BITS       = 48;
    localparam int PRIO_BITS      = 3;

    localparam logic [17:0] PGN_RESERVED  = 18'h0ef00;
    localparam logic [17:0] PGN_DEFAULT   = 18'h0f013;
    localparam logic [13:0] RATE_DEFAULT  = 14'h000a;
    localparam logic [13:0] RATE_ON_REQ   = 14'h0000;
    localparam logic [7:0]  DEST_DEFAULT  = 8'hff;
    localparam logic [3:0]  LEN_DEFAULT   = 4'h8;
    localparam logic [2:0]  PRIO_DEFAULT  = 3'h3;
    localparam logic [3:0]  SRC_NONE      = 4'h0;
    localparam logic [3:0]  SRC_PITCH     = 4'h1;
    localparam logic [3:0]  SRC_ROLL      = 4'h2;
    localparam logic [3:0]  POS_ONE       = 4'h1;
    localparam logic [3:0]  POS_THREE     = 4'h3;
    localparam logic [5:0]  SIZE_ONE      = 6'h01;
    localparam logic [5:0]  SIZE_SIXTEEN  = 6'h10;
    // Resolution is the inverse gain, stored as codes per unit in Q16.16
    localparam logic [31:0] GAIN_UNIT     = 32'h0001_0000;
    localparam logic [31:0] GAIN_CONT_DEF = 32'h01f4_0000;
    // Offset in signal units, Q32.16
    localparam logic [47:0] OFS_ZERO      = 48'h0000_0000_0000;
    localparam logic [47:0] OFS_CONT_DEF  = 48'hffff_ffc0_0000;
    localparam logic [27:0] MS_CYCLES     = 28'd125000;

    typedef enum logic [1:0] {
        SIG_UNDEF = 2'h0,
        SIG_DISCRETE = 2'h1,
        SIG_CONT = 2'h3
    } cosp_sig_type;

    typedef struct packed {
        cosp_sig_type  kind;
        logic [3:0]    src;
        logic [3:0]    byte_pos;
        logic [3:0]    bit_pos;
        logic [5:0]    size;
        logic [31:0]   gain;
        logic [47:0]   offset;
    } cosp_slot_type;

    typedef struct packed {
        logic [17:0]   pgn;
        logic          tx_en;
        logic [13:0]   rate_ms;
        logic [7:0]    dest;
        logic [3:0]    len;
        logic [2:0]    prio;
    } cosp_msg_type;

    typedef struct packed {
        logic [17:0]   pgn;
        logic [7:0]    dest;
        logic [3:0]    len;
        logic [2:0]    prio;
        logic [63:0]   data;
    } cosp_frame_type;
endpackage

//--- core/cosp_slot_coder.sv
`timescale 1ns/10ps
module cosp_slot_coder (
    input  wire cosp_pkg::cosp_slot_type  cfg,
    input  wire logic [31:0]              value,
    input  wire logic                     valid,
    output logic [63:0]                   field,
    output logic [63:0]                   mask
);
    logic [5:0]  start_bit;
    logic [6:0]  stop_bit;
    logic [31:0] size_ones;
    logic [31:0] cont_max;
    logic [31:0] code;
    logic [95:0] prod;
    logic signed [95:0] scaled;
    logic [31:0] clamped;
    logic        over_lim;
    logic        under_lim;

    // Concatenation keeps the byte offset from wrapping at four bits
    assign start_bit = 6'({cfg.byte_pos - 4'h1, 3'h0}) + 6'(cfg.bit_pos - 4'h1);
    assign stop_bit  = 7'(start_bit) + 7'(cfg.size) - 7'h01;
    assign size_ones = (cfg.size >= 6'h20) ? 32'hffff_ffff : ((32'h1 << cfg.size) - 32'h1);
    // Top byte above 0xfa stays reserved; short fields keep only the lower half
    assign cont_max  = (cfg.size >= 6'h08) ? size_ones - (32'h5 << (cfg.size - 6'h08))
                                           : (size_ones >> 1);
    // Code = (value - offset) * gain; value taken as signed Q32.16 units scaled by 2^16
    assign scaled    = 96'(signed'({{16{value[31]}}, value, 16'h0}) - signed'(cfg.offset))
                       * signed'({64'h0, cfg.gain});
    assign prod      = scaled >>> 32;
    assign under_lim = scaled[95];
    assign over_lim  = !scaled[95] && (prod[95:32] != 64'h0 || prod[31:0] > cont_max);
    assign clamped   = under_lim ? 32'h0 : (over_lim ? cont_max : prod[31:0]);

    always_comb begin
        case (cfg.kind)
            cosp_pkg::SIG_DISCRETE: code = value & size_ones;
            cosp_pkg::SIG_CONT:     code = clamped;
            default:                code = size_ones;
        endcase
        if (!valid) begin
            code = size_ones;
        end
    end

    // LSB first from the start bit; bits past 63 are dropped
    assign mask  = (stop_bit > 7'd63) ? ({32'h0, size_ones} << start_bit)
                                      : ({32'h0, size_ones} << start_bit);
    assign field = {32'h0, code & size_ones} << start_bit;
endmodule // cosp_slot_coder

//--- bench/cosp_packer_asserts.sv
`timescale 1ns/10ps
module cosp_packer_asserts (
    input wire logic                     core_clk,
    input wire logic                     rst,
    input wire logic                     cfg_wr,
    input wire logic                     cfg_wr_msg,
    input wire logic [3:0]               cfg_wr_slot,
    input wire cosp_pkg::cosp_msg_type   cfg_wr_msg_data,
    input wire logic                     cfg_wr_identity,
    input wire logic                     cfg_wr_bitrate,
    input wire logic [15:0]              cfg_bitrate,
    input wire logic                     tx_ready,
    input wire logic                     cfg_ack,
    input wire logic                     cfg_reject,
    input wire logic                     nv_save,
    input wire cosp_pkg::cosp_msg_type   nv_msg,
    input wire logic                     nv_bitrate_save,
    input wire logic [15:0]              nv_bitrate,
    input wire logic                     blocks_reset,
    input wire logic                     addr_reclaim,
    input wire logic                     tx_valid,
    input wire cosp_pkg::cosp_frame_type tx_frame
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic bad_msg;
    logic good_wr;
    assign bad_msg = cfg_wr && cfg_wr_msg && cfg_wr_msg_data.pgn == cosp_pkg::PGN_RESERVED;
    assign good_wr = cfg_wr && !bad_msg && (cfg_wr_msg || cfg_wr_slot < 4'ha);
    AST_RESERVED: assert property (bad_msg |=> cfg_reject && !cfg_ack && !nv_save)
        else $error("reserved group number not refused");
    AST_KEEP: assert property (bad_msg |=> $stable(nv_msg))
        else $error("refused write changed message");
    AST_SLOT_RANGE: assert property (cfg_wr && !cfg_wr_msg && cfg_wr_slot > 4'h9 |=> cfg_reject)
        else $error("slot index above nine not refused");
    AST_SAVE: assert property (good_wr |=> cfg_ack && nv_save)
        else $error("write not saved");
    AST_APPLY: assert property (good_wr && cfg_wr_msg |=> nv_msg == $past(cfg_wr_msg_data))
        else $error("message write not applied");
    AST_RESET_ALL: assert property (good_wr |=> blocks_reset)
        else $error("no block reset after change");
    AST_RECLAIM: assert property (good_wr && cfg_wr_identity |=> addr_reclaim)
        else $error("no address reclaim");
    AST_RATE: assert property (cfg_wr_bitrate |=> nv_bitrate_save && nv_bitrate == $past(cfg_bitrate))
        else $error("bit rate not stored");
    AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
        else $error("frame changed before taken");
    cover property (cfg_reject);
    cover property (addr_reclaim);
    cover property (tx_valid && tx_ready);
endmodule // cosp_packer_asserts

bind cosp_packer cosp_packer_asserts i_asserts (
    .core_clk(core_clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_wr_msg(cfg_wr_msg),
    .cfg_wr_slot(cfg_wr_slot), .cfg_wr_msg_data(cfg_wr_msg_data),
    .cfg_wr_identity(cfg_wr_identity), .cfg_wr_bitrate(cfg_wr_bitrate),
    .cfg_bitrate(cfg_bitrate), .tx_ready(tx_ready), .cfg_ack(cfg_ack),
    .cfg_reject(cfg_reject), .nv_save(nv_save), .nv_msg(nv_msg),
    .nv_bitrate_save(nv_bitrate_save), .nv_bitrate(nv_bitrate),
    .blocks_reset(blocks_reset), .addr_reclaim(addr_reclaim),
    .tx_valid(tx_valid), .tx_frame(tx_frame)
);

//--- bench/cosp_sink_model.sv
`timescale 1ns/10ps
module cosp_sink_model (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     tx_valid,
    input  wire cosp_pkg::cosp_frame_type tx_frame,
    input  wire logic [3:0]               stall,
    output logic                          tx_ready,
    output logic [63:0]                   got_data,
    output logic [7:0]                    got_count
);
    logic [3:0] wait_q;
    // Stall count lets the bench play a slow bus
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_ready <= 1'b0;
            wait_q <= 4'h0;
            got_data <= 64'h0;
            got_count <= 8'h0;
        end else if (tx_valid && tx_ready) begin
            tx_ready <= 1'b0;
            wait_q <= 4'h0;
            got_data <= tx_frame.data;
            got_count <= got_count + 8'h1;
        end else if (tx_valid) begin
            tx_ready <= (wait_q >= stall);
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule // cosp_sink_model

//--- bench/test_can_output_signal_packer.sv
`timescale 1ns/10ps
module test_can_output_signal_packer;
    logic                     core_clk, rst, cfg_wr, cfg_wr_msg, cfg_wr_identity;
    logic                     cfg_wr_bitrate, tx_request, tx_ready, cfg_ack, cfg_reject;
    logic                     nv_save, nv_bitrate_save, blocks_reset, addr_reclaim, tx_valid;
    logic [511:0]             src_value;
    logic [15:0]              src_valid, cfg_bitrate, nv_bitrate;
    logic [3:0]               cfg_wr_slot, stall;
    logic [63:0]              got_data;
    logic [7:0]               got_count, c0;
    cosp_pkg::cosp_slot_type  slot_d;
    cosp_pkg::cosp_msg_type   msg_d, nv_msg;
    cosp_pkg::cosp_frame_type tx_frame;
    int                       err_count, checked;

    cosp_packer #(.MS_CYCLES(28'd10)) i_dut (.core_clk(core_clk), .rst(rst),
        .src_value(src_value), .src_valid(src_valid), .cfg_wr(cfg_wr), .cfg_wr_msg(cfg_wr_msg),
        .cfg_wr_slot(cfg_wr_slot), .cfg_wr_slot_data(slot_d), .cfg_wr_msg_data(msg_d),
        .cfg_wr_identity(cfg_wr_identity), .cfg_wr_bitrate(cfg_wr_bitrate),
        .cfg_bitrate(cfg_bitrate), .tx_request(tx_request), .tx_ready(tx_ready),
        .cfg_ack(cfg_ack), .cfg_reject(cfg_reject), .nv_save(nv_save), .nv_msg(nv_msg),
        .nv_bitrate_save(nv_bitrate_save), .nv_bitrate(nv_bitrate),
        .blocks_reset(blocks_reset), .addr_reclaim(addr_reclaim), .tx_valid(tx_valid),
        .tx_frame(tx_frame));
    cosp_sink_model i_sink (.core_clk(core_clk), .rst(rst), .tx_valid(tx_valid),
        .tx_frame(tx_frame), .stall(stall), .tx_ready(tx_ready), .got_data(got_data),
        .got_count(got_count));

    function automatic cosp_pkg::cosp_slot_type sl(input cosp_pkg::cosp_sig_type k,
        input logic [3:0] s, input logic [3:0] b, input logic [3:0] p, input logic [5:0] z);
        return '{k, s, b, p, z, cosp_pkg::GAIN_UNIT, cosp_pkg::OFS_ZERO};
    endfunction
    function automatic cosp_pkg::cosp_msg_type mg(input logic [17:0] g, input logic e,
        input logic [13:0] r);
        return '{g, e, r, cosp_pkg::DEST_DEFAULT, cosp_pkg::LEN_DEFAULT, cosp_pkg::PRIO_DEFAULT};
    endfunction
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cfg(input logic m, input logic [3:0] s, input cosp_pkg::cosp_slot_type sd,
        input cosp_pkg::cosp_msg_type md, input logic id, input logic ok);
        @(posedge core_clk);
        cfg_wr <= 1'b1;
        cfg_wr_msg <= m;
        cfg_wr_slot <= s;
        slot_d <= sd;
        msg_d <= md;
        cfg_wr_identity <= id;
        @(posedge core_clk);
        cfg_wr <= 1'b0;
        #1 check({cfg_ack, cfg_reject, addr_reclaim, blocks_reset}, {ok, !ok, ok & id, ok});
        check(nv_save, ok);
        @(posedge core_clk);
    endtask
    task automatic setsrc(input int i, input logic [31:0] v, input logic ok);
        @(posedge core_clk);
        src_value[i*32+:32] <= v;
        src_valid[i] <= ok;
    endtask
    task automatic send(input logic [63:0] exp);
        int n;
        c0 = got_count;
        @(posedge core_clk);
        tx_request <= 1'b1;
        @(posedge core_clk);
        tx_request <= 1'b0;
        for (n = 0; n < 60 && got_count == c0; n++) @(posedge core_clk);
        #1;
        if (got_count == c0) begin
            err_count++;
            stop_test();
        end else begin
            check(got_data, exp);
            check(tx_frame.pgn, cosp_pkg::PGN_DEFAULT);
        end
    endtask

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        {rst, cfg_wr, cfg_wr_msg, cfg_wr_identity, cfg_wr_bitrate, tx_request} = 6'h20;
        {src_value, src_valid, cfg_bitrate, cfg_wr_slot, stall} = '0;
        {slot_d, msg_d, err_count, checked} = '0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        #1 check({nv_msg.pgn, nv_msg.rate_ms}, {cosp_pkg::PGN_DEFAULT, cosp_pkg::RATE_DEFAULT});
        @(posedge core_clk);
        cfg_wr_bitrate <= 1'b1;
        cfg_bitrate <= 16'h00fa;
        @(posedge core_clk);
        cfg_wr_bitrate <= 1'b0;
        #1 check({nv_bitrate_save, nv_bitrate}, {1'b1, 16'h00fa});
        cfg(1'b1, 4'h0, '0, mg(cosp_pkg::PGN_RESERVED, 1'b1, 14'h0), 1'b0, 1'b0);
        check(nv_msg.pgn, cosp_pkg::PGN_DEFAULT);
        cfg(1'b0, 4'ha, sl(cosp_pkg::SIG_UNDEF, 4'h0, 4'h8, 4'h8, 6'h01), '0, 1'b0, 1'b0);
        // Park slots two to eight on the top bit so defaults of the others show
        for (int i = 2; i < 9; i++)
            cfg(1'b0, i[3:0], sl(cosp_pkg::SIG_UNDEF, 4'h0, 4'h8, 4'h8, 6'h01), '0, 1'b0, 1'b1);
        cfg(1'b1, 4'h0, '0, mg(cosp_pkg::PGN_DEFAULT, 1'b1, cosp_pkg::RATE_ON_REQ), 1'b1, 1'b1);
        setsrc(1, 32'h0, 1'b1);
        setsrc(2, 32'h2, 1'b1);
        send(64'hffffffff_80e8_7d01);
        setsrc(1, 32'h0, 1'b0);
        setsrc(2, 32'd100, 1'b1);
        send(64'hffffffff_faff_ffff);
        setsrc(1, 32'h0, 1'b1);
        setsrc(2, -32'sd100, 1'b1);
        send(64'hffffffff_0000_7d01);
        cfg(1'b0, 4'h2, sl(cosp_pkg::SIG_DISCRETE, 4'h3, 4'h5, 4'h4, 6'h05), '0, 1'b0, 1'b1);
        cfg(1'b0, 4'h9, sl(cosp_pkg::SIG_DISCRETE, 4'h4, 4'h8, 4'h8, 6'h01), '0, 1'b0, 1'b1);
        setsrc(3, 32'h2a, 1'b1);
        setsrc(4, 32'h0, 1'b1);
        stall <= 4'h5;
        send(64'h7fffff57_0000_7d00);
        cfg(1'b1, 4'h0, '0, mg(cosp_pkg::PGN_DEFAULT, 1'b1, 14'h1), 1'b0, 1'b1);
        c0 = got_count;
        repeat (40) @(posedge core_clk);
        check(got_count - c0 > 8'h1, 64'h1);
        cfg(1'b1, 4'h0, '0, mg(cosp_pkg::PGN_DEFAULT, 1'b1, cosp_pkg::RATE_ON_REQ), 1'b0, 1'b1);
        repeat (20) @(posedge core_clk);
        c0 = got_count;
        repeat (40) @(posedge core_clk);
        check(got_count - c0, 64'h0);
        stop_test();
    end
endmodule // test_can_output_signal_packer
